/* core/twm_master.sv */
// Purpose: single-master two-wire controller with Avalon-MM register access
// Assumes: bit clock comes from an outside timer, sampled by core_clk
// Notes:   clock and data pins are open drain, driven only low
//
// Behaviour
// - transmit busy rises when any byte send starts, falls when it ends
// - after a sent byte the ack bit reads 0 for ACK, 1 for NAK
// - transmit and receive execute together: transmit goes first
// - receive releases data line, clocks, shifts bits in MSB first
// - receive execute clears when the first, MSB bit is taken
// - when the ninth pulse ends the shift register is copied to the data field
// - receive ready sets on that copy and clears on a data read
// - receive busy high from start of byte reception until done
// - received byte takes nine pulses; ninth drives the ack bit
// - stop raises data while clock high, frees bus, clears stop bit
// - start while busy makes a repeated start, bus stays busy
// - one interrupt output shared by both causes
// - transmit cause raised when data moves into shift register
// - data write clears transmit cause; without execute nothing is sent
// - receive cause raised when received data lands in data field
// - data read clears receive cause
// - no register tells which cause fired
// - registers are 16 bits, reserved bits read zero
// - enable bit starts and stops the module, resets to 0
// - start on free bus pulls data low with clock high, marks busy
// - sent bits change at falling clock, MSB first, ninth released
// - bit clock from outside timer drives shifting and the clock pin
// - noise filter bit filters both line inputs
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "twm_map.svh"

module twm_master
  import twm_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic [17:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        bit_clk_in,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             irq
);

  // synchronisers and filtered lines
  twm_lines_t             ln_s1_r;
  twm_lines_t             ln_s2_r;
  twm_lines_t             ln_f_r;
  logic [`TWM_NF_LEN-1:0] hs_scl_r;
  logic [`TWM_NF_LEN-1:0] hs_sda_r;
  logic                   tc_s1_r;
  logic                   tc_s2_r;
  logic                   tc_d_r;
  logic                   t_rise;
  logic                   t_fall;

  // bus slave
  logic                   wait_r;
  logic [31:0]            rdata_r;
  logic [15:0]            rd_mux;
  logic                   wr_acc;
  logic                   rd_acc;
  logic                   sel_en;
  logic                   sel_ctl;
  logic                   sel_dat;
  logic                   sel_ie;
  logic                   wr_lo;
  logic                   wr_hi;

  // software registers
  logic                   en_r;
  logic                   nf_r;
  logic                   start_r;
  logic                   stop_r;
  logic                   tie_r;
  logic                   rie_r;
  logic                   txe_r;
  logic                   rxe_r;
  logic                   ack_r;
  logic [7:0]             data_r;
  logic                   rdy_r;
  logic                   txc_r;
  logic                   irq_r;

  // engine
  twm_state_t             state_r;
  logic [3:0]             cnt_r;
  logic [7:0]             sh_r;
  logic                   rx_r;
  logic                   smpd_r;
  logic                   smp_r;
  logic                   scl_oe_r;
  logic                   sda_oe_r;
  logic                   transmit_busy_flag_r;
  logic                   receive_busy_flag_r;
  logic                   busy_r;
  logic                   go_start;
  logic                   go_tx;
  logic                   go_rx;
  logic                   go_stop;
  logic [3:0]             cnt_nxt;
  twm_ev_t                ev;

  // open drain: the driven level is always low
  assign scl_out         = 1'b0;
  assign sda_out         = 1'b0;
  assign scl_oe          = scl_oe_r;
  assign sda_oe          = sda_oe_r;
  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign irq             = irq_r;

  // two-flop synchronisers for pins and timer clock
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ln_s1_r <= '{scl: 1'b1, sda: 1'b1};
      ln_s2_r <= '{scl: 1'b1, sda: 1'b1};
      tc_s1_r <= 1'b0;
      tc_s2_r <= 1'b0;
      tc_d_r  <= 1'b0;
    end else begin
      ln_s1_r <= '{scl: scl_in, sda: sda_in};
      ln_s2_r <= ln_s1_r;
      tc_s1_r <= bit_clk_in;
      tc_s2_r <= tc_s1_r;
      tc_d_r  <= tc_s2_r;
    end
  end

  // bit clock edges
  assign t_rise = tc_s2_r & ~tc_d_r;
  assign t_fall = ~tc_s2_r & tc_d_r;

  // noise filter: a level changes only after equal samples in a row
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hs_scl_r <= '1;
      hs_sda_r <= '1;
      ln_f_r   <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      hs_scl_r <= {hs_scl_r[`TWM_NF_LEN-2:0], ln_s2_r.scl};
      hs_sda_r <= {hs_sda_r[`TWM_NF_LEN-2:0], ln_s2_r.sda};
      if (!nf_r) begin
        ln_f_r <= ln_s2_r;
      end else begin
        if (&hs_scl_r) ln_f_r.scl <= 1'b1;
        else if (~|hs_scl_r) ln_f_r.scl <= 1'b0;
        if (&hs_sda_r) ln_f_r.sda <= 1'b1;
        else if (~|hs_sda_r) ln_f_r.sda <= 1'b0;
      end
    end
  end

  // address decode and accepted accesses
  always_comb begin
    sel_en  = 1'b0;
    sel_ctl = 1'b0;
    sel_dat = 1'b0;
    sel_ie  = 1'b0;
    if (avs_address == {`TWM_IDX_EN, 2'b00}) sel_en = 1'b1;
    else if (avs_address == {`TWM_IDX_CTL, 2'b00}) sel_ctl = 1'b1;
    else if (avs_address == {`TWM_IDX_DAT, 2'b00}) sel_dat = 1'b1;
    else if (avs_address == {`TWM_IDX_IE, 2'b00}) sel_ie = 1'b1;
  end

  assign wr_acc = avs_write & ~wait_r;
  assign rd_acc = avs_read & ~wait_r;
  assign wr_lo  = wr_acc & avs_byteenable[0];
  assign wr_hi  = wr_acc & avs_byteenable[1];

  // read mux, reserved bits zero
  always_comb begin
    rd_mux = `TWM_RST16;
    if (sel_en) begin
      rd_mux[`TWM_EN_BIT] = en_r;
    end else if (sel_ctl) begin
      rd_mux[`TWM_START_REQUEST_BIT_BIT] = start_r;
      rd_mux[`TWM_STOP_BIT] = stop_r;
      rd_mux[`TWM_NF_BIT]   = nf_r;
      rd_mux[`TWM_TBSY_BIT] = transmit_busy_flag_r;
      rd_mux[`TWM_RBSY_BIT] = receive_busy_flag_r;
    end else if (sel_dat) begin
      rd_mux[7:0]          = data_r;
      rd_mux[`TWM_ACK_BIT] = ack_r;
      rd_mux[`TWM_TXE_BIT] = txe_r;
      rd_mux[`TWM_RXE_BIT] = rxe_r;
      rd_mux[`TWM_RDY_BIT] = rdy_r;
    end else if (sel_ie) begin
      rd_mux[`TWM_TIE_BIT] = tie_r;
      rd_mux[`TWM_RIE_BIT] = rie_r;
    end
  end

  // one wait state per access; read data captured with it
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h00000000;
    end else if ((avs_read | avs_write) && wait_r) begin
      wait_r  <= 1'b0;
      rdata_r <= {16'h0000, rd_mux};
    end else begin
      wait_r  <= 1'b1;
    end
  end

  // decisions taken from idle
  assign go_start = en_r & start_r;
  assign go_tx    = en_r & ~start_r & txe_r;
  assign go_rx    = en_r & ~start_r & ~txe_r & rxe_r;
  assign go_stop  = en_r & ~start_r & ~txe_r & ~rxe_r & stop_r;
  assign cnt_nxt  = cnt_r + 4'h1;

  // engine events, decoded from the state machine for the software registers
  always_comb begin
    ev            = '0;
    ev.tx_load    = (state_r == TWM_IDLE) & go_tx;
    ev.rx_first   = (state_r == TWM_BIT_HI) & rx_r & ~smpd_r & ln_f_r.scl
                    & (cnt_r == `TWM_CNT0);
    ev.tx_done    = (state_r == TWM_BIT_HI) & ~rx_r & t_fall & smpd_r
                    & (cnt_r == `TWM_ACK_SLOT);
    ev.rx_done    = (state_r == TWM_BIT_HI) & rx_r & t_fall & smpd_r
                    & (cnt_r == `TWM_ACK_SLOT);
    ev.start_done = (state_r == TWM_ST_SET) & t_rise;
    ev.stop_done  = ((state_r == TWM_SP_REL) & t_fall & ln_f_r.scl)
                    | ((state_r == TWM_IDLE) & go_stop & ~busy_r);
  end

  // software registers, hardware updates after so that sets win
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      en_r    <= 1'b0;
      nf_r    <= 1'b0;
      start_r <= 1'b0;
      stop_r  <= 1'b0;
      tie_r   <= 1'b0;
      rie_r   <= 1'b0;
      txe_r   <= 1'b0;
      rxe_r   <= 1'b0;
      ack_r   <= 1'b0;
      data_r  <= `TWM_RST8;
      rdy_r   <= 1'b0;
      txc_r   <= 1'b0;
    end else begin
      if (wr_lo && sel_en) en_r <= avs_writedata[`TWM_EN_BIT];
      if (wr_lo && sel_ctl) begin
        nf_r    <= avs_writedata[`TWM_NF_BIT];
        start_r <= avs_writedata[`TWM_START_REQUEST_BIT_BIT];
        stop_r  <= avs_writedata[`TWM_STOP_BIT];
      end
      if (wr_lo && sel_ie) begin
        tie_r <= avs_writedata[`TWM_TIE_BIT];
        rie_r <= avs_writedata[`TWM_RIE_BIT];
      end
      if (wr_lo && sel_dat) begin
        data_r <= avs_writedata[7:0];
        txc_r  <= 1'b0;
      end
      if (wr_hi && sel_dat) begin
        ack_r <= avs_writedata[`TWM_ACK_BIT];
        txe_r <= avs_writedata[`TWM_TXE_BIT];
        rxe_r <= avs_writedata[`TWM_RXE_BIT];
      end
      if (rd_acc && sel_dat) rdy_r <= 1'b0;
      // hardware side
      if (ev.tx_load) begin
        txc_r <= 1'b1;
        if (!(wr_hi && sel_dat)) txe_r <= 1'b0;
      end
      if (ev.rx_first && !(wr_hi && sel_dat)) rxe_r <= 1'b0;
      if (ev.rx_done) begin
        data_r <= sh_r;
        rdy_r  <= 1'b1;
      end
      if (ev.tx_done) ack_r <= smp_r;
      if (ev.start_done && !(wr_lo && sel_ctl)) start_r <= 1'b0;
      if (ev.stop_done && !(wr_lo && sel_ctl)) stop_r <= 1'b0;
    end
  end

  // shared interrupt, no cause register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) irq_r <= 1'b0;
    else irq_r <= (txc_r & tie_r) | (rdy_r & rie_r);
  end

  // bus state machine
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r  <= TWM_IDLE;
      cnt_r    <= `TWM_CNT0;
      sh_r     <= `TWM_RST8;
      rx_r     <= 1'b0;
      smpd_r   <= 1'b0;
      smp_r    <= 1'b0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      transmit_busy_flag_r  <= 1'b0;
      receive_busy_flag_r  <= 1'b0;
      busy_r   <= 1'b0;
    end else if (!en_r) begin
      state_r  <= TWM_IDLE;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      transmit_busy_flag_r  <= 1'b0;
      receive_busy_flag_r  <= 1'b0;
      busy_r   <= 1'b0;
    end else begin
      case (state_r)
        TWM_IDLE: begin
          if (go_start) begin
            if (busy_r) begin
              sda_oe_r <= 1'b0;
              state_r  <= TWM_ST_RLS;
            end else begin
              scl_oe_r <= 1'b0;
              state_r  <= TWM_ST_HLD;
            end
          end else if (go_tx) begin
            sh_r    <= data_r;
            rx_r    <= 1'b0;
            cnt_r   <= `TWM_CNT0;
            transmit_busy_flag_r <= 1'b1;
            state_r <= TWM_BIT_SU;
          end else if (go_rx) begin
            rx_r    <= 1'b1;
            cnt_r   <= `TWM_CNT0;
            receive_busy_flag_r <= 1'b1;
            state_r <= TWM_BIT_SU;
          end else if (go_stop && busy_r) begin
            state_r <= TWM_SP_LOW;
          end
        end
        // repeated start: release clock with data high
        TWM_ST_RLS: begin
          if (t_rise) begin
            scl_oe_r <= 1'b0;
            state_r  <= TWM_ST_HLD;
          end
        end
        // data falls while clock line is high
        TWM_ST_HLD: begin
          if (t_fall && ln_f_r.scl) begin
            sda_oe_r <= 1'b1;
            state_r  <= TWM_ST_SET;
          end
        end
        TWM_ST_SET: begin
          if (t_rise) begin
            scl_oe_r <= 1'b1;
            busy_r   <= 1'b1;
            state_r  <= TWM_IDLE;
          end
        end
        // first bit placed at a falling edge
        TWM_BIT_SU: begin
          if (t_fall) begin
            scl_oe_r <= 1'b1;
            sda_oe_r <= rx_r ? 1'b0 : ~sh_r[7];
            state_r  <= TWM_BIT_LO;
          end
        end
        TWM_BIT_LO: begin
          if (t_rise) begin
            scl_oe_r <= 1'b0;
            smpd_r   <= 1'b0;
            state_r  <= TWM_BIT_HI;
          end
        end
        // sample once the line is really high, then wait falling edge
        TWM_BIT_HI: begin
          if (!smpd_r && ln_f_r.scl) begin
            smpd_r <= 1'b1;
            smp_r  <= ln_f_r.sda;
            if (rx_r && cnt_r != `TWM_ACK_SLOT) begin
              sh_r <= {sh_r[6:0], ln_f_r.sda};
            end
          end
          if (t_fall && smpd_r) begin
            scl_oe_r <= 1'b1;
            if (cnt_r == `TWM_ACK_SLOT) begin
              sda_oe_r <= 1'b0;
              transmit_busy_flag_r  <= 1'b0;
              receive_busy_flag_r  <= 1'b0;
              state_r  <= TWM_IDLE;
            end else begin
              cnt_r <= cnt_nxt;
              if (!rx_r) sh_r <= {sh_r[6:0], 1'b0};
              if (cnt_nxt == `TWM_ACK_SLOT) begin
                sda_oe_r <= rx_r ? ~ack_r : 1'b0;
              end else begin
                sda_oe_r <= rx_r ? 1'b0 : ~sh_r[6];
              end
              state_r <= TWM_BIT_LO;
            end
          end
        end
        // stop: data low, clock high, then data high
        TWM_SP_LOW: begin
          if (t_fall) begin
            sda_oe_r <= 1'b1;
            state_r  <= TWM_SP_HI;
          end
        end
        TWM_SP_HI: begin
          if (t_rise) begin
            scl_oe_r <= 1'b0;
            state_r  <= TWM_SP_REL;
          end
        end
        TWM_SP_REL: begin
          if (t_fall && ln_f_r.scl) begin
            sda_oe_r <= 1'b0;
            busy_r   <= 1'b0;
            state_r  <= TWM_IDLE;
          end
        end
        default: state_r <= TWM_IDLE;
      endcase
    end
  end

endmodule // twm_master

/* core/twm_map.svh */
// Purpose: register indices, field positions and counts of the two-wire master
// Assumes: byte address of a register is four times its index
// Notes:   definitions only
`ifndef TWM_MAP_SVH
`define TWM_MAP_SVH

// register indices; byte address is the index shifted left by two
`define TWM_IDX_EN   16'h4340
`define TWM_IDX_CTL  16'h4342
`define TWM_IDX_DAT  16'h4344
`define TWM_IDX_IE   16'h4346

// module_enable fields
`define TWM_EN_BIT   0
// control_status fields
`define TWM_START_REQUEST_BIT_BIT 0
`define TWM_STOP_BIT 1
`define TWM_NF_BIT   4
`define TWM_TBSY_BIT 8
`define TWM_RBSY_BIT 9
// transfer_data fields
`define TWM_ACK_BIT  8
`define TWM_TXE_BIT  9
`define TWM_RXE_BIT  10
`define TWM_RDY_BIT  11
// interrupt_enable fields
`define TWM_TIE_BIT  0
`define TWM_RIE_BIT  1

// reset values and counts
`define TWM_RST16    16'h0000
`define TWM_RST8     8'h00
`define TWM_CNT0     4'h0
`define TWM_ACK_SLOT 4'h8
`define TWM_NF_LEN   3

`endif

/* core/twm_pkg.sv */
// Purpose: shared types of the two-wire master
// Assumes: constants live in twm_map.svh
// Notes:   states, line bundle and engine events
package twm_pkg;

  typedef enum logic [3:0] {
    TWM_IDLE   = 4'b0000,
    TWM_ST_RLS = 4'b0001,
    TWM_ST_HLD = 4'b0010,
    TWM_ST_SET = 4'b0011,
    TWM_BIT_SU = 4'b0100,
    TWM_BIT_LO = 4'b0101,
    TWM_BIT_HI = 4'b0110,
    TWM_SP_LOW = 4'b0111,
    TWM_SP_HI  = 4'b1000,
    TWM_SP_REL = 4'b1001
  } twm_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } twm_lines_t;

  typedef struct packed {
    logic tx_load;
    logic tx_done;
    logic rx_first;
    logic rx_done;
    logic start_done;
    logic stop_done;
  } twm_ev_t;

endpackage

/* test/twm_master_props.sv */
// Purpose: port checks of the two-wire master
// Assumes: register byte address is index times four
// Notes:   enable bits are mirrored from completed writes
`timescale 1ns/1ns
`include "twm_map.svh"
module twm_master_props
  import twm_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic [17:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        scl_in,
  input wire logic        scl_out,
  input wire logic        scl_oe,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic        irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic        en_r;
  logic [1:0]  ie_r;
  logic [15:0] rsv;
  wire         wr_w = !avs_waitrequest && avs_write && avs_byteenable[0];
  // mirror of enable and interrupt enable bits
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      en_r <= 1'b0;
      ie_r <= 2'b00;
    end else if (wr_w && avs_address[17:2] == `TWM_IDX_EN) begin
      en_r <= avs_writedata[0];
    end else if (wr_w && avs_address[17:2] == `TWM_IDX_IE) begin
      ie_r <= avs_writedata[1:0];
    end
  end
  // reserved bits of the addressed register
  always_comb begin
    case (avs_address[17:2])
      `TWM_IDX_EN:  rsv = 16'hFFFE;
      `TWM_IDX_CTL: rsv = 16'hFCEC;
      `TWM_IDX_DAT: rsv = 16'hF000;
      `TWM_IDX_IE:  rsv = 16'hFFFC;
      default:      rsv = 16'hFFFF;
    endcase
  end
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_rest: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest dropped without request");
  a_rsv_zero: assert property (!avs_waitrequest && avs_read |->
    (avs_readdata[15:0] & rsv) == 16'h0000 && avs_readdata[31:16] == 16'h0000)
    else $error("reserved read bits not zero");
  a_pins_low: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("pin driven high");
  a_irq_masked: assert property (irq |-> ie_r != 2'b00 || $past(ie_r) != 2'b00)
    else $error("interrupt with both causes masked");
  a_en_read: assert property (!avs_waitrequest && avs_read && avs_address[17:2] == `TWM_IDX_EN
    |-> avs_readdata[0] == en_r)
    else $error("enable bit reads wrong");
  a_off_free: assert property (!en_r && !$past(en_r) && !$past(en_r, 2) |-> !scl_oe && !sda_oe)
    else $error("pins driven while disabled");
  a_stop_idle: assert property ($fell(sda_oe) && scl_in && !scl_oe |=> !scl_oe [*8])
    else $error("clock pulled soon after stop");
  a_start_clock: assert property ($rose(sda_oe) && scl_in && !scl_oe |-> ##[1:20] scl_oe)
    else $error("no clock low after start");
  c_start: cover property ($rose(sda_oe) && scl_in && !scl_oe);
  c_stop: cover property ($fell(sda_oe) && scl_in && !scl_oe);
  c_irq: cover property ($rose(irq));
endmodule // twm_master_props

bind twm_master twm_master_props u_props (.core_clk, .rst_b, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .scl_in,
  .scl_out, .scl_oe, .sda_out, .sda_oe, .irq);

/* test/twm_slave_model.sv */
// Purpose: behavioural two-wire slave on the far side of the master
// Assumes: lines are wired-and with pull-ups in the bench
// Notes:   first byte bit 0 picks direction; optional clock stretch
`timescale 1ns/1ns
module twm_slave_model (
  input  wire logic        scl,
  input  wire logic        sda,
  input  wire logic        nak,
  input  wire logic        stretch,
  input  wire logic [15:0] rd_pair,
  output logic             scl_oe,
  output logic             sda_oe,
  output logic [7:0]       got,
  output int               cnt,
  output logic             mack,
  output int               stops
);
  logic [7:0] sh;
  int         bitn;
  logic       first, rdm, act, rk;
  // idle state
  initial begin
    {scl_oe, sda_oe, mack, first, rdm, act, rk} = 7'h00;
    {got, sh} = 16'h0000;
    {cnt, stops, bitn} = {32'd0, 32'd0, 32'd0};
  end
  // start and repeated start; scl is looked at 1 ns later so that a data
  // change launched together with a falling clock is not taken for one
  always @(negedge sda) begin
    #1;
    if (scl) begin
      {act, first, rdm, rk, sda_oe} = 5'b11000;
      bitn = 0;
    end
  end
  // stop, with the same settling time
  always @(posedge sda) begin
    #1;
    if (scl && act) begin
      act = 1'b0;
      stops++;
    end
  end
  // sample data bits and the ninth bit
  always @(posedge scl) if (act) begin
    if (bitn < 8) sh = {sh[6:0], sda};
    else mack = sda;
    bitn++;
  end
  // drive after the falling clock, then stretch if asked
  always @(negedge scl) if (act) begin
    if (bitn == 9) begin
      bitn = 0;
      if (!rdm) begin
        got = sh;
        cnt++;
      end else if (mack) rdm = 1'b0; // master refused: let go
      else rk = !rk;
      if (first) rdm = sh[0];
      first = 1'b0;
    end
    sda_oe = rdm ? (bitn < 8 && !rd_pair[(rk ? 7 : 15) - bitn]) : (bitn == 8 && !nak);
    if (stretch) begin
      scl_oe = 1'b1;
      #100;
      scl_oe = 1'b0;
    end
  end
endmodule // twm_slave_model

/* test/testbench.sv */
// Purpose: self-checking bench of the two-wire master
// Assumes: bus answers after one wait cycle, lines pulled up
// Notes:   two passes, second with filter and a stretching slave
`timescale 1ns/1ns
`include "twm_map.svh"
module testbench;
  localparam logic [15:0] r_en = `TWM_IDX_EN, r_ctl = `TWM_IDX_CTL;
  localparam logic [15:0] r_dat = `TWM_IDX_DAT, r_ie = `TWM_IDX_IE;
  logic        core_clk, rst_b, avs_read, avs_write, bit_clk_in, nak, stretch, nf;
  logic        avs_waitrequest, scl_out, scl_oe, sda_out, sda_oe, irq, s_scl, s_sda, mack;
  logic [17:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic [15:0] q, rd_pair;
  logic [7:0]  got, ad, db;
  int          cnt, stops, n_fail, compares, c0;
  wire         scl_w = !(scl_oe || s_scl);
  wire         sda_w = !(sda_oe || s_sda);
  twm_master dut (.core_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .bit_clk_in, .scl_in(scl_w), .scl_out,
    .scl_oe, .sda_in(sda_w), .sda_out, .sda_oe, .irq);
  twm_slave_model peer (.scl(scl_w), .sda(sda_w), .nak, .stretch, .rd_pair, .scl_oe(s_scl),
    .sda_oe(s_sda), .got, .cnt, .mack, .stops);
  // core clock and free-running bit clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    bit_clk_in = 1'b0;
    #1;
    forever #24 bit_clk_in = ~bit_clk_in;
  end
  task automatic test_done;
    $display("fails %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one bus access, held until waitrequest is seen low
  task automatic acc(input logic wr, input logic [15:0] idx, input logic [15:0] d);
    int n;
    n = 0;
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {16'h0000, d};
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 50) chk(16'h0000, 16'h0001);
    q = avs_readdata[15:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic poll(input logic [15:0] idx, input logic [15:0] m, input logic [15:0] v);
    int n;
    n = 0;
    acc(1'b0, idx, 16'h0000);
    while ((q & m) !== v && n < 3000) begin
      acc(1'b0, idx, 16'h0000);
      n++;
    end
    chk(q & m, v);
  endtask
  task automatic irqchk(input logic e);
    repeat (3) @(posedge core_clk);
    chk({15'h0000, irq}, {15'h0000, e});
  endtask
  task automatic tx(input logic [7:0] b);
    acc(1'b1, r_dat, {8'h02, b});
    poll(r_ctl, 16'h0100, 16'h0100);
    poll(r_ctl, 16'h0100, 16'h0000);
  endtask
  // tail of a reception: execute bit clears early, busy stays up
  task automatic rxt;
    poll(r_dat, 16'h0400, 16'h0000);
    acc(1'b0, r_ctl, 16'h0000);
    chk(q & 16'h0300, 16'h0200);
    poll(r_ctl, 16'h0200, 16'h0000);
  endtask
  // watchdog
  initial begin
    #200000;
    chk(16'h0000, 16'h0001);
    test_done;
  end
  // main sequence
  initial begin
    {rst_b, avs_read, avs_write, nak, stretch} = 5'b00000;
    avs_address = 18'h00000;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
    rd_pair = 16'h0000;
    {n_fail, compares} = {32'd0, 32'd0};
    void'($urandom(93242));
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 5; i++) begin
      acc(1'b0, 16'(16'h4340 + 2 * i), 16'h0000);
      chk(q, 16'h0000);
    end
    for (int it = 0; it < 2; it++) begin
      nf = it[0];
      stretch <= 1'b0;
      acc(1'b1, r_en, 16'h0001);
      acc(1'b0, r_en, 16'h0000);
      chk(q, 16'h0001);
      acc(1'b1, r_ie, 16'h0001);
      acc(1'b1, r_ctl, {11'h000, nf, 4'h1});
      poll(r_ctl, 16'h0001, 16'h0000);
      ad = {7'($urandom), 1'b0};
      tx(ad);
      chk(got, ad);
      acc(1'b0, r_dat, 16'h0000);
      chk(q & 16'h0100, 16'h0000);
      irqchk(1'b1);
      db = 8'($urandom);
      nak <= 1'b1;
      tx(db);
      chk(got, db);
      acc(1'b0, r_dat, 16'h0000);
      chk(q & 16'h0100, 16'h0100);
      nak <= 1'b0;
      c0 = cnt;
      acc(1'b1, r_dat, 16'h00A5);
      irqchk(1'b0);
      repeat (200) @(posedge core_clk);
      chk(16'(cnt - c0), 16'h0000);
      acc(1'b1, r_ctl, {11'h000, nf, 4'h1});
      poll(r_ctl, 16'h0001, 16'h0000);
      acc(1'b1, r_ie, 16'h0002);
      irqchk(1'b0);
      stretch <= it[0];
      rd_pair <= 16'($urandom);
      acc(1'b1, r_dat, {8'h06, ad | 8'h01});
      poll(r_ctl, 16'h0300, 16'h0100);
      rxt;
      chk(got, ad | 8'h01);
      irqchk(1'b1);
      acc(1'b0, r_dat, 16'h0000);
      chk(q, {8'h08, rd_pair[15:8]});
      irqchk(1'b0);
      acc(1'b0, r_dat, 16'h0000);
      chk(q & 16'h0800, 16'h0000);
      chk({15'h0000, mack}, 16'h0000);
      acc(1'b1, r_dat, 16'h0500);
      rxt;
      chk({15'h0000, mack}, 16'h0001);
      acc(1'b0, r_dat, 16'h0000);
      chk(q, {8'h09, rd_pair[7:0]});
      repeat (40) @(posedge core_clk);
      acc(1'b1, r_ctl, {11'h000, nf, 4'h2});
      poll(r_ctl, 16'h0002, 16'h0000);
      chk(16'(stops), 16'(it + 1));
      chk({14'h0000, scl_w, sda_w}, 16'h0003);
      acc(1'b1, r_en, 16'h0000);
      repeat (3) @(posedge core_clk);
      chk({14'h0000, scl_oe, sda_oe}, 16'h0000);
    end
    test_done;
  end
endmodule // testbench
